// [src/sls_consts.svh]
`ifndef SLS_CONSTS_SVH
`define SLS_CONSTS_SVH

// ==========================================================================
// Register map (word aligned byte offsets)
`define SLS_ADDR_CTRL      8'h00
`define SLS_ADDR_COND      8'h04
`define SLS_ADDR_LAMPS     8'h08
`define SLS_ADDR_STAT      8'h0C
`define SLS_ADDR_BLINK     8'h10

// ==========================================================================
// Control register fields
`define SLS_CTRL_FUNCTION_BUTTON_ACQ  0
`define SLS_CTRL_MEDIA_LOG 1
`define SLS_CTRL_UPD_MODE  2

// Condition register fields (written by host software)
`define SLS_COND_BOOTING   0
`define SLS_COND_BOOTED    1
`define SLS_COND_SHUTDOWN  2
`define SLS_COND_CONFIG    3
`define SLS_COND_SCHED_W   4
`define SLS_COND_SCHED_MET 5
`define SLS_COND_ACQ       6
`define SLS_COND_ERROR     7
`define SLS_COND_LOGGING   8
`define SLS_COND_UPD_RUN   9
`define SLS_COND_UPD_FILE  10
`define SLS_COND_UPD_NOFL  11
`define SLS_COND_UPD_OK    12
`define SLS_COND_UPD_FAIL  13
`define SLS_COND_W         14

// Status register fields
`define SLS_STAT_ERR       0
`define SLS_STAT_UNMNT     1
`define SLS_STAT_EJECT     2
`define SLS_STAT_DEFAULTS  3
`define SLS_STAT_REBOOT    4

// ==========================================================================
// Timing, 100 MHz clock
`define SLS_CLK_HZ         100000000
`define SLS_FLASH_ON_MS    100
`define SLS_FLASH_OFF_MS   2000
`define SLS_REBOOT_S       5
`define SLS_FLASH_ON_CYC   ((`SLS_CLK_HZ / 1000) * `SLS_FLASH_ON_MS)
`define SLS_FLASH_OFF_CYC  ((`SLS_CLK_HZ / 1000) * `SLS_FLASH_OFF_MS)
`define SLS_REBOOT_CYC     (`SLS_CLK_HZ * `SLS_REBOOT_S)
`define SLS_BLINK_RST      32'h02FA_F080

`endif

// [src/sls_pkg.sv]
package sls_pkg;
  // Lamp colour driven on a bicolour lamp
  typedef enum logic [1:0] {
    SLS_OFF,
    SLS_GREEN,
    SLS_YELLOW
  } sls_colour_type;
endpackage

// [src/sls_top.sv]
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`include "sls_consts.svh"

module sls_top #(
  parameter int unsigned FLASH_ON_CYC  = `SLS_FLASH_ON_CYC,
  parameter int unsigned FLASH_OFF_CYC = `SLS_FLASH_OFF_CYC,
  parameter int unsigned REBOOT_CYC    = `SLS_REBOOT_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sd_present_i,
  input  wire logic        usb_present_i,
  input  wire logic        function_button_i,
  input  wire logic        defaults_button_i,
  output logic      [1:0]  power_lamp_o,
  output logic      [1:0]  status_lamp_o,
  output logic      [1:0]  error_lamp_o,
  output logic      [1:0]  media_lamp_o,
  output logic             unmount_req_o,
  output logic             write_defaults_o,
  output logic             reboot_o
);

  // ========================================================================
  // Register bus
  logic [2:0]  ctrl_ff;
  logic [`SLS_COND_W-1:0] cond_ff;
  logic [31:0] blink_per_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;

  wire         bus_req  = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire         bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
  wire         wr_ctrl  = bus_wr & (wb_adr_i == `SLS_ADDR_CTRL);
  wire         wr_cond  = bus_wr & (wb_adr_i == `SLS_ADDR_COND);
  wire         wr_blink = bus_wr & (wb_adr_i == `SLS_ADDR_BLINK);

  // Pin synchronisers: stage one feeds stage two only
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  wire        sd_in    = sync2_ff[0];
  wire        usb_in   = sync2_ff[1];
  wire        fbtn_in  = sync2_ff[2];
  wire        dbtn_in  = sync2_ff[3];
  logic       fbtn_d_ff;
  logic       dbtn_d_ff;
  wire        fbtn_rise = fbtn_in & ~fbtn_d_ff;
  wire        dbtn_rise = dbtn_in & ~dbtn_d_ff;
  wire        media_in  = sd_in | usb_in;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1_ff  <= 4'h0;
      sync2_ff  <= 4'h0;
      fbtn_d_ff <= 1'b0;
      dbtn_d_ff <= 1'b0;
    end else begin
      sync1_ff  <= {defaults_button_i, function_button_i, usb_present_i, sd_present_i};
      sync2_ff  <= sync1_ff;
      fbtn_d_ff <= fbtn_in;
      dbtn_d_ff <= dbtn_in;
    end
  end

  // Condition decode
  wire booting   = cond_ff[`SLS_COND_BOOTING];
  wire booted    = cond_ff[`SLS_COND_BOOTED];
  wire shutdown  = cond_ff[`SLS_COND_SHUTDOWN];
  wire cfg_run   = cond_ff[`SLS_COND_CONFIG];
  wire sched_w   = cond_ff[`SLS_COND_SCHED_W];
  wire sched_met = cond_ff[`SLS_COND_SCHED_MET];
  wire acq       = cond_ff[`SLS_COND_ACQ];
  wire err_in    = cond_ff[`SLS_COND_ERROR];
  wire logging   = cond_ff[`SLS_COND_LOGGING];
  wire upd_run   = cond_ff[`SLS_COND_UPD_RUN];
  wire upd_file  = cond_ff[`SLS_COND_UPD_FILE];
  wire upd_nofl  = cond_ff[`SLS_COND_UPD_NOFL];
  wire upd_ok    = cond_ff[`SLS_COND_UPD_OK];
  wire upd_fail  = cond_ff[`SLS_COND_UPD_FAIL];
  wire function_button_acq  = ctrl_ff[`SLS_CTRL_FUNCTION_BUTTON_ACQ];
  wire media_job = ctrl_ff[`SLS_CTRL_MEDIA_LOG];
  wire upd_mode  = ctrl_ff[`SLS_CTRL_UPD_MODE];
  wire pend_job  = media_job & ~acq;
  wire sched_beg = wr_cond & wb_dat_i[`SLS_COND_SCHED_W] & ~sched_w;

  // ========================================================================
  // Blink timebase: one shared period, heartbeat from a 4-phase slot
  logic [31:0] blink_cnt_ff;
  logic        blink_ff;
  logic [1:0]  hb_ph_ff;
  wire         blink_wrap = (blink_cnt_ff >= blink_per_ff);

  // Heartbeat lit in one phase of four, so it reads slower than the plain blink
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      blink_cnt_ff <= 32'h0000_0000;
      blink_ff     <= 1'b0;
      hb_ph_ff     <= 2'h0;
    end else if (blink_wrap) begin
      blink_cnt_ff <= 32'h0000_0000;
      blink_ff     <= ~blink_ff;
      hb_ph_ff     <= hb_ph_ff + 2'h1;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
    end
  end
  wire heartbeat = blink_ff & ~hb_ph_ff[1];

  // Schedule wait flash, 100 ms lit then 2 s dark
  logic [31:0] flash_cnt_ff;
  wire         flash_on   = (flash_cnt_ff < FLASH_ON_CYC);
  wire         flash_last = (flash_cnt_ff == FLASH_ON_CYC + FLASH_OFF_CYC - 1);

  always_ff @(posedge clk_i) begin
    if (!rstn_i || !sched_w || flash_last) begin
      flash_cnt_ff <= 32'h0000_0000;
    end else begin
      flash_cnt_ff <= flash_cnt_ff + 32'h0000_0001;
    end
  end

  // ========================================================================
  // Latches: error, unmount, update entry, reboot timer
  logic        err_ff;
  logic        unmnt_ff;
  logic        upd_start_ff;
  logic        upd_mode_d_ff;
  logic [31:0] reboot_cnt_ff;
  logic        reboot_ff;
  logic        defaults_ff;
  logic        eject_ff;
  wire         eject_ok = fbtn_rise & ~function_button_acq & ~pend_job & media_in;
  wire         reboot_done = upd_ok & (reboot_cnt_ff == REBOOT_CYC - 1);

  // Error set wins over clear at schedule start
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      err_ff <= 1'b0;
    end else if (err_in) begin
      err_ff <= 1'b1;
    end else if (sched_beg) begin
      err_ff <= 1'b0;
    end
  end

  // Unmounted media is held until withdrawn
  always_ff @(posedge clk_i) begin
    if (!rstn_i || !media_in) begin
      unmnt_ff <= 1'b0;
    end else if (eject_ok) begin
      unmnt_ff <= 1'b1;
    end
  end

  // Update entry lasts until the update reports any progress
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      upd_mode_d_ff <= 1'b0;
      upd_start_ff  <= 1'b0;
    end else begin
      upd_mode_d_ff <= upd_mode;
      if (upd_mode & ~upd_mode_d_ff) begin
        upd_start_ff <= 1'b1;
      end else if (!upd_mode || upd_run || upd_file || upd_nofl || upd_ok || upd_fail) begin
        upd_start_ff <= 1'b0;
      end
    end
  end

  // Reboot after update success, or straight after defaults are written
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      reboot_cnt_ff <= 32'h0000_0000;
      reboot_ff     <= 1'b0;
      defaults_ff   <= 1'b0;
      eject_ff      <= 1'b0;
    end else begin
      eject_ff    <= eject_ok;
      defaults_ff <= dbtn_rise;
      reboot_ff   <= reboot_done | defaults_ff;
      if (upd_ok && upd_mode && !reboot_done) begin
        reboot_cnt_ff <= reboot_cnt_ff + 32'h0000_0001;
      end else begin
        reboot_cnt_ff <= 32'h0000_0000;
      end
    end
  end

  // ========================================================================
  // Lamp schemes, update scheme has priority
  sls_pkg::sls_colour_type n_pwr, n_sts, n_err, n_med;
  sls_pkg::sls_colour_type u_pwr, u_sts, u_err, u_med;

  // Blinking colour; one helper, the caller picks the phase (blink_ff, heartbeat or flash_on)
  function automatic sls_pkg::sls_colour_type blink_col(
    input sls_pkg::sls_colour_type c,
    input logic                    lit
  );
    return lit ? c : sls_pkg::SLS_OFF;
  endfunction

  // Normal operation scheme
  always_comb begin
    n_pwr = sls_pkg::SLS_OFF;
    if (shutdown) n_pwr = blink_col(sls_pkg::SLS_YELLOW, blink_ff);
    else if (booting) n_pwr = sls_pkg::SLS_YELLOW;
    else if (booted) n_pwr = sls_pkg::SLS_GREEN;
    n_sts = sls_pkg::SLS_OFF;
    if (cfg_run) n_sts = blink_col(sls_pkg::SLS_YELLOW, blink_ff);
    else if (acq) n_sts = blink_col(sls_pkg::SLS_GREEN, blink_ff);
    else if (sched_met) n_sts = blink_col(sls_pkg::SLS_GREEN, heartbeat);
    else if (sched_w) n_sts = blink_col(sls_pkg::SLS_GREEN, flash_on);
    else if (booted) n_sts = sls_pkg::SLS_GREEN;
    n_err = blink_col(sls_pkg::SLS_YELLOW, err_ff & blink_ff);
    n_med = sls_pkg::SLS_OFF;
    if (media_in) begin
      if (unmnt_ff) n_med = sls_pkg::SLS_GREEN;
      else if (logging && acq) n_med = blink_col(sls_pkg::SLS_GREEN, blink_ff);
      else if (pend_job) n_med = blink_col(sls_pkg::SLS_YELLOW, blink_ff);
      else n_med = sls_pkg::SLS_YELLOW;
    end else if (pend_job) begin
      n_med = blink_col(sls_pkg::SLS_YELLOW, blink_ff);
    end
  end

  // Update scheme
  always_comb begin
    u_pwr = blink_col(sls_pkg::SLS_YELLOW, blink_ff);
    u_sts = sls_pkg::SLS_OFF;
    if (upd_file) u_sts = blink_col(sls_pkg::SLS_GREEN, blink_ff);
    else if (upd_nofl) u_sts = blink_col(sls_pkg::SLS_YELLOW, blink_ff);
    u_err = sls_pkg::SLS_OFF;
    if (upd_ok) u_err = blink_col(sls_pkg::SLS_GREEN, blink_ff);
    else if (upd_fail) u_err = blink_col(sls_pkg::SLS_YELLOW, blink_ff);
    u_med = sls_pkg::SLS_OFF;
    if (upd_start_ff) begin
      u_pwr = sls_pkg::SLS_YELLOW;
      u_sts = sls_pkg::SLS_YELLOW;
      u_err = sls_pkg::SLS_YELLOW;
      u_med = sls_pkg::SLS_YELLOW;
    end
  end

  // Lamp outputs registered
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      power_lamp_o  <= 2'h0;
      status_lamp_o <= 2'h0;
      error_lamp_o  <= 2'h0;
      media_lamp_o  <= 2'h0;
    end else begin
      power_lamp_o  <= upd_mode ? u_pwr : n_pwr;
      status_lamp_o <= upd_mode ? u_sts : n_sts;
      error_lamp_o  <= upd_mode ? u_err : n_err;
      media_lamp_o  <= upd_mode ? u_med : n_med;
    end
  end

  assign unmount_req_o    = eject_ff;
  assign write_defaults_o = defaults_ff;
  assign reboot_o         = reboot_ff;

  // ========================================================================
  // Register writes and read mux
  wire [31:0] stat_word = {27'h0, reboot_ff, defaults_ff, eject_ff, unmnt_ff, err_ff};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (wb_adr_i)
      `SLS_ADDR_CTRL:  rd_mux = {29'h0, ctrl_ff};
      `SLS_ADDR_COND:  rd_mux = {18'h0, cond_ff};
      `SLS_ADDR_LAMPS: rd_mux = {24'h0, media_lamp_o, error_lamp_o, status_lamp_o, power_lamp_o};
      `SLS_ADDR_STAT:  rd_mux = stat_word;
      `SLS_ADDR_BLINK: rd_mux = blink_per_ff;
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // Single wait state ack; unmapped reads as zero, writes dropped
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ctrl_ff      <= 3'h0;
      cond_ff      <= '0;
      blink_per_ff <= `SLS_BLINK_RST;
      ack_ff       <= 1'b0;
      rdat_ff      <= 32'h0000_0000;
    end else begin
      ack_ff  <= bus_req;
      rdat_ff <= bus_req ? rd_mux : 32'h0000_0000;
      if (wr_ctrl) ctrl_ff <= wb_dat_i[2:0];
      if (wr_cond) cond_ff <= wb_dat_i[`SLS_COND_W-1:0];
      if (wr_blink) blink_per_ff <= wb_dat_i;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // ========================================================================
  // Checks: error latch and its clear at schedule start
  a_err_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
    err_in |=> err_ff) else $error("error not latched");
  a_err_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (sched_beg && !err_in) |=> !err_ff) else $error("error not cleared");
  // Update scheme lamps and reboot
  a_update_prio: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (upd_mode && upd_start_ff) |=> (media_lamp_o == 2'(sls_pkg::SLS_YELLOW)))
    else $error("update entry not all yellow");
  a_update_power: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (upd_mode && !upd_start_ff && blink_ff) |=> (power_lamp_o == 2'(sls_pkg::SLS_YELLOW)))
    else $error("update power lamp not lit");
  a_update_fail: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (upd_mode && !upd_start_ff && upd_fail && !upd_ok && blink_ff)
    |=> (error_lamp_o == 2'(sls_pkg::SLS_YELLOW))) else $error("update fail lamp wrong");
  a_update_reboot: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (upd_mode && upd_ok && (reboot_cnt_ff == REBOOT_CYC - 1)) |=> reboot_o)
    else $error("no reboot after update");
  // Eject gating and media lamp
  a_eject_block: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (function_button_acq || pend_job) |=> !unmount_req_o) else $error("eject not blocked");
  a_unmount_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (media_in && unmnt_ff && !upd_mode) |=> (media_lamp_o == 2'(sls_pkg::SLS_GREEN)))
    else $error("unmounted media lamp not green");
  a_media_steady: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (media_in && !unmnt_ff && !pend_job && !(logging && acq) && !upd_mode)
    |=> (media_lamp_o == 2'(sls_pkg::SLS_YELLOW))) else $error("media lamp not yellow");
  a_media_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!media_in && !pend_job && !upd_mode) |=> (media_lamp_o == 2'h0))
    else $error("media lamp not off");
  // Power and status lamps
  a_boot_yellow: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (booting && !shutdown && !upd_mode) |=> (power_lamp_o == 2'(sls_pkg::SLS_YELLOW)))
    else $error("boot lamp wrong");
  a_flash_lit: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (sched_w && !sched_met && !acq && !cfg_run && !upd_mode && (flash_cnt_ff == 32'h0000_0000))
    |=> (status_lamp_o == 2'(sls_pkg::SLS_GREEN))) else $error("schedule flash not lit");
  // Buttons and bus
  a_defaults_reboot: assert property (@(posedge clk_i) disable iff (!rstn_i)
    write_defaults_o |=> reboot_o) else $error("no reboot after defaults");
  a_bus_ack: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack late");
  c_eject: cover property (@(posedge clk_i) unmount_req_o);
  c_update: cover property (@(posedge clk_i) upd_mode && upd_start_ff);
  c_reboot: cover property (@(posedge clk_i) reboot_o);
  c_heartbeat: cover property (@(posedge clk_i) sched_met && heartbeat);
  c_flash: cover property (@(posedge clk_i) sched_w && flash_last);

endmodule // sls_top

// [verification/sls_panel.sv]
`timescale 1ns/100ps
// ========
// Panel model: media sockets and pushbuttons
module sls_panel (
  input  wire logic clk_i,
  input  wire logic sd_in_i,
  input  wire logic usb_in_i,
  input  wire logic fn_push_i,
  input  wire logic def_push_i,
  output logic      sd_present_o,
  output logic      usb_present_o,
  output logic      fn_btn_o,
  output logic      def_btn_o
);
  logic       sd_ff = 1'b0;
  logic       usb_ff = 1'b0;
  logic [2:0] fn_ff = 3'h0;
  logic [2:0] def_ff = 3'h0;
  // A press is held for a few cycles like a finger, so only one rise is seen
  always_ff @(posedge clk_i) begin
    sd_ff  <= sd_in_i;
    usb_ff <= usb_in_i;
    fn_ff  <= fn_push_i ? 3'h7 : fn_ff - {2'h0, fn_ff != 3'h0};
    def_ff <= def_push_i ? 3'h7 : def_ff - {2'h0, def_ff != 3'h0};
  end
  // Outputs are the held states
  assign sd_present_o  = sd_ff;
  assign usb_present_o = usb_ff;
  assign fn_btn_o      = fn_ff != 3'h0;
  assign def_btn_o     = def_ff != 3'h0;
endmodule // sls_panel

// [verification/sls_top_tb_top.sv]
`timescale 1ns/100ps
`include "sls_consts.svh"
// ========
// Bench top
module sls_top_tb_top;
  localparam int unsigned ON_C = 10;
  localparam int unsigned OFF_C = 40;
  localparam int unsigned RB_C = 50;
  localparam logic [1:0] OF = sls_pkg::SLS_OFF;
  localparam logic [1:0] GR = sls_pkg::SLS_GREEN;
  localparam logic [1:0] YE = sls_pkg::SLS_YELLOW;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        sd_in = 1'b0;
  logic        usb_in = 1'b0;
  logic        fn_push = 1'b0;
  logic        def_push = 1'b0;
  logic        sd_p, usb_p, fn_b, def_b;
  logic        unm, wdef, rbt;
  logic [1:0]  lamp [4];
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc_cnt = 0;

  always #5 clk_i = ~clk_i;

  sls_top #(.FLASH_ON_CYC(ON_C), .FLASH_OFF_CYC(OFF_C), .REBOOT_CYC(RB_C)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sd_present_i(sd_p), .usb_present_i(usb_p), .function_button_i(fn_b),
    .defaults_button_i(def_b), .power_lamp_o(lamp[0]), .status_lamp_o(lamp[1]),
    .error_lamp_o(lamp[2]), .media_lamp_o(lamp[3]), .unmount_req_o(unm),
    .write_defaults_o(wdef), .reboot_o(rbt));

  sls_panel u_panel (
    .clk_i(clk_i), .sd_in_i(sd_in), .usb_in_i(usb_in), .fn_push_i(fn_push),
    .def_push_i(def_push), .sd_present_o(sd_p), .usb_present_o(usb_p),
    .fn_btn_o(fn_b), .def_btn_o(def_b));

  // ========
  // Checking and closing
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // Expected sets of colours seen on one lamp
  function automatic logic [3:0] steady(input logic [1:0] c);
    return 4'h1 << c;
  endfunction
  function automatic logic [3:0] blink(input logic [1:0] c);
    return 4'h1 | (4'h1 << c);
  endfunction
  function automatic logic [31:0] b(input int i);
    return 32'h1 << i;
  endfunction

  // ========
  // Bus cycles: request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, 4'hF, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, 4'hF, r);
    chk(r, e);
  endtask

  // ========
  // Lamp and pulse observers
  task automatic watch(input int k, input int n, output logic [3:0] s);
    s = 4'h0;
    repeat (n) begin
      @(posedge clk_i);
      s[lamp[k]] = 1'b1;
    end
  endtask
  // Length of the next whole run of colour c
  task automatic runlen(input int k, input logic [1:0] c, output int n);
    int w;
    w = 0;
    n = 0;
    while (lamp[k] === c && w < 400) begin @(posedge clk_i); w++; end
    while (lamp[k] !== c && w < 400) begin @(posedge clk_i); w++; end
    while (lamp[k] === c && w < 400) begin @(posedge clk_i); w++; n++; end
  endtask
  task automatic pulses(input int n, output int fu, output int fd, output int fr);
    fu = -1;
    fd = -1;
    fr = -1;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      if (unm === 1'b1 && fu < 0) fu = i;
      if (wdef === 1'b1 && fd < 0) fd = i;
      if (rbt === 1'b1 && fr < 0) fr = i;
    end
  endtask
  // Pressing a button through the panel model
  task automatic press(input logic def);
    @(posedge clk_i);
    if (def) def_push <= 1'b1;
    else fn_push <= 1'b1;
    @(posedge clk_i);
    def_push <= 1'b0;
    fn_push <= 1'b0;
  endtask

  // ========
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [3:0]  s;
    int          n, fu, fd, fr, per;
    int          bt;
    bt = `SLS_COND_BOOTED;
    r = $urandom(32'hA79D);
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk({lamp[0], lamp[1], lamp[2], lamp[3], unm, wdef, rbt}, 32'h0);
    rd(`SLS_ADDR_BLINK, 32'h02FA_F080);
    rd(8'h3C, 32'h0);
    // Writes without byte lane 0 are dropped
    wb(1'b1, `SLS_ADDR_BLINK, $urandom, 4'hE, r);
    rd(`SLS_ADDR_BLINK, 32'h02FA_F080);
    per = 2 + $urandom_range(4);
    wr(`SLS_ADDR_BLINK, per);
    wr(`SLS_ADDR_COND, b(`SLS_COND_BOOTING));
    watch(0, 20, s); chk(s, steady(YE));
    wr(`SLS_ADDR_COND, b(bt));
    watch(0, 20, s); chk(s, steady(GR));
    watch(1, 20, s); chk(s, steady(GR));
    wr(`SLS_ADDR_COND, b(bt) | b(`SLS_COND_SHUTDOWN));
    watch(0, 40, s); chk(s, blink(YE));
    runlen(0, YE, n); chk(n, per + 1);
    wr(`SLS_ADDR_COND, 32'h0);
    watch(0, 20, s); chk(s, steady(OF));
    wr(`SLS_ADDR_COND, b(bt) | b(`SLS_COND_CONFIG));
    watch(1, 40, s); chk(s, blink(YE));
    wr(`SLS_ADDR_COND, b(bt) | b(`SLS_COND_SCHED_W));
    runlen(1, GR, n); chk(n, ON_C);
    runlen(1, OF, n); chk(n, OFF_C);
    wr(`SLS_ADDR_COND, b(bt) | b(`SLS_COND_SCHED_MET));
    watch(1, 40, s); chk({s[0], s[3:1] != 3'h0}, 2'h3);
    runlen(1, OF, n); chk(n, 3 * (per + 1));
    wr(`SLS_ADDR_COND, b(bt) | b(`SLS_COND_ACQ));
    watch(1, 40, s); chk(s, blink(GR));
    // Error latch survives the error bit falling, cleared by schedule start
    wr(`SLS_ADDR_COND, b(bt) | b(`SLS_COND_ERROR));
    watch(2, 30, s); chk(s, blink(YE));
    wr(`SLS_ADDR_COND, b(bt));
    watch(2, 30, s); chk(s, blink(YE));
    rd(`SLS_ADDR_STAT, b(`SLS_STAT_ERR));
    wr(`SLS_ADDR_COND, b(bt) | b(`SLS_COND_SCHED_W));
    watch(2, 30, s); chk(s, steady(OF));
    wr(`SLS_ADDR_COND, b(bt));
    // Media pending job, button set for acquisitions, then a real eject
    @(posedge clk_i);
    sd_in <= 1'b1;
    wr(`SLS_ADDR_CTRL, b(`SLS_CTRL_MEDIA_LOG));
    watch(3, 30, s); chk(s, blink(YE));
    press(1'b0);
    pulses(30, fu, fd, fr); chk(fu, -1);
    wr(`SLS_ADDR_CTRL, b(`SLS_CTRL_FUNCTION_BUTTON_ACQ));
    watch(3, 20, s); chk(s, steady(YE));
    press(1'b0);
    pulses(30, fu, fd, fr); chk(fu, -1);
    wr(`SLS_ADDR_CTRL, 32'h0);
    press(1'b0);
    pulses(30, fu, fd, fr); chk(fu >= 0, 1'b1);
    watch(3, 20, s); chk(s, steady(GR));
    @(posedge clk_i);
    sd_in <= 1'b0;
    repeat (6) @(posedge clk_i);
    watch(3, 20, s); chk(s, steady(OF));
    usb_in <= 1'b1;
    repeat (6) @(posedge clk_i);
    watch(3, 20, s); chk(s, steady(YE));
    wr(`SLS_ADDR_COND, b(bt) | b(`SLS_COND_ACQ) | b(`SLS_COND_LOGGING));
    watch(3, 40, s); chk(s, blink(GR));
    // Update mode scheme
    wr(`SLS_ADDR_CTRL, b(`SLS_CTRL_UPD_MODE));
    rd(`SLS_ADDR_LAMPS, 32'hAA);
    watch(1, 20, s); chk(s, steady(YE));
    wr(`SLS_ADDR_COND, b(`SLS_COND_UPD_RUN) | b(`SLS_COND_UPD_FILE));
    watch(0, 40, s); chk(s, blink(YE));
    watch(1, 40, s); chk(s, blink(GR));
    wr(`SLS_ADDR_COND, b(`SLS_COND_UPD_RUN) | b(`SLS_COND_UPD_NOFL));
    watch(1, 40, s); chk(s, blink(YE));
    wr(`SLS_ADDR_COND, b(`SLS_COND_UPD_FAIL));
    watch(2, 40, s); chk(s, blink(YE));
    pulses(RB_C + 10, fu, fd, fr); chk(fr, -1);
    wr(`SLS_ADDR_COND, b(`SLS_COND_UPD_OK));
    pulses(RB_C + 10, fu, fd, fr);
    chk(fr >= RB_C - 3 && fr <= RB_C + 2, 1'b1);
    watch(2, 40, s); chk(s, blink(GR));
    // Factory defaults then reboot
    wr(`SLS_ADDR_CTRL, 32'h0);
    wr(`SLS_ADDR_COND, 32'h0);
    press(1'b1);
    pulses(30, fu, fd, fr); chk(fd >= 0, 1'b1);
    chk(fr, fd + 1);
    tally_and_finish();
  end
endmodule // sls_top_tb_top
